// [verilog/hpbp_port.sv]
`timescale 1ns/100ps
`include "hpbp_regs.svh"
// Behaviour
// - Mode strap high selects transparent mode, low selects buffered mode.
// - Cycle runs only while data strobe and chip select are both low.
// - Space select high reaches memory, low reaches the register set.
// - Buffered 16-bit with polarity low: direction low reads, high writes.
// - Otherwise direction high reads and direction low writes.
// - Buffer enable goes low only in transparent mode, while the host is granted access.
// - In buffered mode width select high means 16-bit, low means 8-bit.
// - Ready rises once read data is out or write has landed.
module hpbp_port (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic CE,
	// Configuration straps
	input wire logic TRANSPARENT_MODE,
	input wire logic WIDTH_16,
	input wire logic POLARITY_SEL,
	// Host cycle control
	input wire logic DATA_STROBE_N,
	input wire logic SELECT_N,
	input wire logic MEM_SPACE,
	input wire logic RD_WR,
	input wire logic [`HPBP_MEM_AW-1:0] ADDR,
	input wire logic [15:0] WDATA,
	// Answers
	output logic [15:0] RDATA,
	output logic CYCLE_READY_OUT,
	output logic EXT_BUFFER_ENABLE_N,
	output logic MODE_16BIT,
	output logic TRANSPARENT_ACTIVE
);
	hpbp_pkg::hpbp_state_t state_r, state_nxt;
	logic is_read_r, is_mem_r, width16_r, transp_r;
	logic [`HPBP_MEM_AW-1:0] addr_r;
	logic [15:0] wdata_r;
	logic [2:0] cnt_r;
	logic [15:0] regs_r [0:(1<<`HPBP_REG_AW)-1];
	logic [15:0] mem_rdata;
	logic [15:0] reg_rdata_r;

	// Decode direction from the polarity rules
	function automatic logic dir_is_read(input logic transp, input logic w16,
		input logic pol, input logic rdwr);
		if (!transp && w16 && !pol) begin
			dir_is_read = ~rdwr;
		end else begin
			dir_is_read = rdwr;
		end
	endfunction : dir_is_read

	wire cycle_qual = ~DATA_STROBE_N & ~SELECT_N;
	wire start = (state_r == hpbp_pkg::HPBP_IDLE) && cycle_qual;
	wire in_read = dir_is_read(TRANSPARENT_MODE, WIDTH_16, POLARITY_SEL, RD_WR);
	// Completion needs a live strobe too, so a cycle dropped on its last wait writes nothing
	wire done = (state_r == hpbp_pkg::HPBP_WAIT) && (cnt_r == `HPBP_ACCESS_CYCLES)
		&& cycle_qual;
	wire mem_we = done && is_mem_r && !is_read_r;
	// Width is only meaningful in buffered mode; transparent is always full word
	wire w16_eff = TRANSPARENT_MODE | WIDTH_16;

	// Sequencer: idle, wait for access, ready, hold until strobe drops
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			hpbp_pkg::HPBP_IDLE: begin
				if (cycle_qual) begin
					state_nxt = hpbp_pkg::HPBP_WAIT;
				end
			end
			hpbp_pkg::HPBP_WAIT: begin
				if (!cycle_qual) begin
					state_nxt = hpbp_pkg::HPBP_IDLE;
				end else if (done) begin
					state_nxt = hpbp_pkg::HPBP_DONE;
				end
			end
			hpbp_pkg::HPBP_DONE: begin
				state_nxt = hpbp_pkg::HPBP_HOLD;
			end
			hpbp_pkg::HPBP_HOLD: begin
				if (!cycle_qual) begin
					state_nxt = hpbp_pkg::HPBP_IDLE;
				end
			end
			default: begin
				state_nxt = hpbp_pkg::HPBP_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			state_r <= hpbp_pkg::HPBP_IDLE;
		end else if (CE) begin
			state_r <= state_nxt;
		end
	end

	// Capture cycle attributes once; host may change pins mid-cycle safely
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			is_read_r <= 1'b0;
			is_mem_r <= 1'b0;
			addr_r <= '0;
			wdata_r <= 16'h0000;
		end else if (CE && start) begin
			is_read_r <= in_read;
			is_mem_r <= MEM_SPACE;
			addr_r <= ADDR;
			wdata_r <= WDATA;
		end
	end

	// Access latency counter
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			cnt_r <= 3'h0;
		end else if (CE) begin
			cnt_r <= (state_r == hpbp_pkg::HPBP_WAIT) ? cnt_r + 3'h1 : 3'h0;
		end
	end

	// Mode straps are sampled after reset release, never under reset
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			transp_r <= 1'b0;
			width16_r <= 1'b0;
		end else if (CE) begin
			transp_r <= TRANSPARENT_MODE;
			width16_r <= w16_eff;
		end
	end

	// Internal register set, written at the end of a register write cycle
	always_ff @(posedge CORE_CLK) begin
		if (CE) begin
			if (done && !is_mem_r && !is_read_r) begin
				regs_r[addr_r[`HPBP_REG_AW-1:0]] <= wdata_r;
			end
			reg_rdata_r <= regs_r[addr_r[`HPBP_REG_AW-1:0]];
		end
	end

	hpbp_mem u_mem (
		.clk(CORE_CLK),
		.ce(CE),
		.we(mem_we),
		.addr(addr_r),
		.wdata(wdata_r),
		.rdata_r(mem_rdata)
	);

	// Outputs from flops; ready and read data rise together
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			RDATA <= 16'h0000;
			CYCLE_READY_OUT <= 1'b0;
			EXT_BUFFER_ENABLE_N <= 1'b1;
			MODE_16BIT <= 1'b0;
			TRANSPARENT_ACTIVE <= 1'b0;
		end else if (CE) begin
			if (done && is_read_r) begin
				RDATA <= is_mem_r ? mem_rdata : reg_rdata_r;
			end
			CYCLE_READY_OUT <= done || (state_r == hpbp_pkg::HPBP_DONE)
				|| ((state_r == hpbp_pkg::HPBP_HOLD) && cycle_qual);
			// Buffers open only in transparent mode and only for a live cycle
			EXT_BUFFER_ENABLE_N <= ~(transp_r && cycle_qual);
			MODE_16BIT <= width16_r;
			TRANSPARENT_ACTIVE <= transp_r;
		end
	end

	// Handshake: ready only after a counted access, never after an abort
	ready_after_done_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		CE && done |=> CYCLE_READY_OUT)
		else $error("ready missing after access");
	ready_cause_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		$rose(CYCLE_READY_OUT) |-> $past(state_r == hpbp_pkg::HPBP_WAIT))
		else $error("ready without access");
	abort_quiet_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		CE && state_r == hpbp_pkg::HPBP_WAIT && !cycle_qual |=> !CYCLE_READY_OUT)
		else $error("ready after aborted cycle");
	ready_release_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		CE && state_r == hpbp_pkg::HPBP_HOLD && !cycle_qual |=> !CYCLE_READY_OUT)
		else $error("ready held after strobe release");
	// Read data comes from the space captured at cycle start
	mem_route_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		CE && done && is_read_r && is_mem_r |=> RDATA == $past(mem_rdata))
		else $error("memory read data not routed");
	reg_route_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		CE && done && is_read_r && !is_mem_r |=> RDATA == $past(reg_rdata_r))
		else $error("register read data not routed");
	// Buffer enable only for a live transparent cycle; a frozen edge is not judged
	buf_enable_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		!EXT_BUFFER_ENABLE_N && $past(CE) |-> $past(transp_r && cycle_qual))
		else $error("buffer enable without cycle");
	buf_closed_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		CE && !transp_r |=> EXT_BUFFER_ENABLE_N)
		else $error("buffer enable in buffered mode");
	idle_hold_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		CE && state_r == hpbp_pkg::HPBP_IDLE && !cycle_qual
		|=> state_r == hpbp_pkg::HPBP_IDLE)
		else $error("cycle without strobe and select");
	attr_stable_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		state_r == hpbp_pkg::HPBP_WAIT && $past(state_r) == hpbp_pkg::HPBP_WAIT
		|-> $stable(is_read_r) && $stable(is_mem_r))
		else $error("cycle attributes changed");
	pol_read_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		CE && start && !TRANSPARENT_MODE && WIDTH_16 && !POLARITY_SEL
		|=> is_read_r == !$past(RD_WR))
		else $error("inverted polarity read wrong");
	norm_read_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		CE && start && (TRANSPARENT_MODE || !WIDTH_16 || POLARITY_SEL)
		|=> is_read_r == $past(RD_WR))
		else $error("normal polarity read wrong");
	space_capture_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		CE && start |=> is_mem_r == $past(MEM_SPACE))
		else $error("space select not captured");
	// Strap mirrors lag two edges; the edge just after reset still shows reset values
	mode_track_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		CE && $past(CE) && $past(NRST) |-> ##1 TRANSPARENT_ACTIVE == $past(TRANSPARENT_MODE, 2))
		else $error("mode output wrong");
	width_track_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		CE && $past(CE) && $past(NRST) |-> ##1 MODE_16BIT == $past(TRANSPARENT_MODE || WIDTH_16, 2))
		else $error("width output wrong");
endmodule : hpbp_port

// [verilog/hpbp_regs.svh]
`ifndef HPBP_REGS_SVH
`define HPBP_REGS_SVH
// Access wait count in core clocks; ready comes this count plus one clock after cycle capture
`define HPBP_ACCESS_CYCLES 3'h2
// Memory word count and address width
`define HPBP_MEM_AW 12
`define HPBP_MEM_WORDS 4096
// Internal register set address width
`define HPBP_REG_AW 4
`endif

// [verilog/hpbp_pkg.sv]
package hpbp_pkg;
	// Cycle sequencer states, Gray coded along the path
	typedef enum logic [1:0] {
		HPBP_IDLE = 2'b00,
		HPBP_WAIT = 2'b01,
		HPBP_DONE = 2'b11,
		HPBP_HOLD = 2'b10
	} hpbp_state_t;
endpackage : hpbp_pkg

// [verilog/hpbp_mem.sv]
`timescale 1ns/100ps
`include "hpbp_regs.svh"
module hpbp_mem (
	// Clock
	input wire logic clk,
	input wire logic ce,
	// Access
	input wire logic we,
	input wire logic [`HPBP_MEM_AW-1:0] addr,
	input wire logic [15:0] wdata,
	output logic [15:0] rdata_r
);
	logic [15:0] mem [0:`HPBP_MEM_WORDS-1];

	// Registered read, no reset so it maps to block RAM
	always_ff @(posedge clk) begin
		if (ce) begin
			if (we) begin
				mem[addr] <= wdata;
			end
			rdata_r <= mem[addr];
		end
	end
endmodule : hpbp_mem

// [testbench/hpbp_host.sv]
`timescale 1ns/100ps
// Host CPU with decoder; released lines show the inverse of their last value
module hpbp_host (
	// Clock, straps and answer
	input wire logic clk,
	input wire logic tm,
	input wire logic w16,
	input wire logic pol,
	input wire logic ready,
	// Cycle lines
	output logic strb_n,
	output logic sel_n,
	output logic mem,
	output logic rdwr,
	output logic [11:0] addr,
	output logic [15:0] wdata
);
	logic rd_r;
	// Idle at time zero
	initial begin
		{strb_n, sel_n, rd_r} = 3'h6;
		{mem, rdwr, addr, wdata} = 30'h0;
	end
	// One strobe cycle; ab above zero drops the strobe early
	task automatic cyc(input logic rd, m, sh, input logic [11:0] a,
		input logic [15:0] d, input int ab, hold);
		@(posedge clk);
		#1;
		rd_r = rd;
		rdwr = (!tm && w16 && !pol) ? !rd : rd;
		{mem, addr, wdata} = {m, a, d};
		strb_n = 1'b0;
		sel_n = sh;
		if (ab > 0) begin
			repeat (ab) @(posedge clk);
		end else begin
			for (int i = 0; i < 20 && !ready; i++) @(posedge clk) #1;
			repeat (hold + 1) @(posedge clk);
		end
		#1;
		{strb_n, sel_n} = 2'h3;
		{mem, rdwr, addr, wdata} = ~{mem, rdwr, addr, wdata};
		// A new cycle waits until ready is seen low
		for (int i = 0; i < 20 && ready; i++) @(posedge clk) #1;
	endtask : cyc
endmodule : hpbp_host

// [testbench/hpbp_tb_top.sv]
`timescale 1ns/100ps
module host_processor_bus_port_tb_top;
	logic CORE_CLK = 1'b0, NRST = 1'b0, tm = 1'b0, w16 = 1'b0, pol = 1'b0, rdy_q = 1'b0;
	logic strb_n, sel_n, mem, rdwr, rdy, bufn, m16, ta;
	logic ce = 1'b1;
	logic [11:0] addr;
	logic [15:0] wdata, rdata;
	logic [15:0] ref_m [int];
	logic [15:0] exp_q [$];
	int bad_count = 0, cmp_count = 0, cyc_n = 0, seed = 35;
	// 40 MHz core clock
	always #12.5 CORE_CLK = ~CORE_CLK;
	hpbp_port dut_u (.CORE_CLK(CORE_CLK), .NRST(NRST), .CE(ce), .TRANSPARENT_MODE(tm),
		.WIDTH_16(w16), .POLARITY_SEL(pol), .DATA_STROBE_N(strb_n), .SELECT_N(sel_n),
		.MEM_SPACE(mem), .RD_WR(rdwr), .ADDR(addr), .WDATA(wdata), .RDATA(rdata),
		.CYCLE_READY_OUT(rdy), .EXT_BUFFER_ENABLE_N(bufn), .MODE_16BIT(m16),
		.TRANSPARENT_ACTIVE(ta));
	hpbp_host host_u (.clk(CORE_CLK), .tm(tm), .w16(w16), .pol(pol), .ready(rdy),
		.strb_n(strb_n), .sel_n(sel_n), .mem(mem), .rdwr(rdwr), .addr(addr), .wdata(wdata));
	task automatic chk(input string n, input logic [15:0] e, g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Single-bit flags
	task automatic chk_bit(input string n, input logic e, g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %b seen %b", n, e, g);
		end
	endtask : chk_bit
	task automatic tally_and_finish;
		// A read whose ready never came leaves its note behind
		if (exp_q.size() != 0) begin
			bad_count++;
			$display("MISMATCH pending_reads expected 0 seen %0d", exp_q.size());
		end
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	// Note the expected word, then run the cycle; registers decode low 4 bits
	task automatic acc(input logic rd, m, input logic [11:0] a, input logic [15:0] d, input int h);
		int k;
		k = m ? int'(a) : 4096 + int'(a[3:0]);
		if (rd) exp_q.push_back(ref_m[k]);
		else ref_m[k] = d;
		host_u.cyc(rd, m, 1'b0, a, d, 0, h);
	endtask : acc
	// First ready cycle is paired with the oldest read note
	always @(posedge CORE_CLK) begin
		rdy_q <= rdy;
		if (rdy && !rdy_q) begin
			chk_bit("buffer_enable_n", !tm, bufn);
			if (host_u.rd_r) chk("rdata", exp_q.pop_front(), rdata);
		end
	end
	// Hang guard, well above the several hundred cycles needed
	always @(posedge CORE_CLK) begin
		cyc_n++;
		if (cyc_n == 8000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	initial begin
		logic [11:0] a;
		logic [15:0] d;
		repeat (3) @(posedge CORE_CLK);
		#1;
		chk_bit("reset_ready", 1'b0, rdy);
		chk_bit("reset_buffer_enable_n", 1'b1, bufn);
		NRST = 1'b1;
		// Every strap set, both spaces, varied host hold
		for (int s = 0; s < 8; s++) begin
			{tm, w16, pol} = s[2:0];
			repeat (3) @(posedge CORE_CLK);
			#1;
			chk_bit("transparent_active", tm, ta);
			chk_bit("mode_16bit", tm | w16, m16);
			for (int i = 0; i < 4; i++) begin
				a = 12'($random(seed));
				d = 16'($random(seed));
				acc(1'b0, i[0], a, d, i);
				acc(1'b1, i[0], a, d, 3 - i);
			end
			$display("strap set %0d done", s);
		end
		// Aborted write and a cycle without select must leave memory alone
		a = 12'h0A5;
		acc(1'b0, 1'b1, a, 16'h1234, 0);
		host_u.cyc(1'b0, 1'b1, 1'b0, a, 16'hEDCB, 2, 0);
		acc(1'b1, 1'b1, a, 16'h0000, 0);
		host_u.cyc(1'b0, 1'b1, 1'b1, a, 16'h5555, 8, 0);
		chk_bit("ready", 1'b0, rdy);
		// Clock enable low for three edges mid-cycle must keep ready low until the third frozen edge has passed
		fork
			acc(1'b1, 1'b1, a, 16'h0000, 0);
			begin
				repeat (2) @(posedge CORE_CLK);
				#1;
				ce = 1'b0;
				repeat (3) @(posedge CORE_CLK);
				#1;
				chk_bit("ready_frozen", 1'b0, rdy);
				ce = 1'b1;
			end
		join
		$display("abort test done");
		repeat (4) @(posedge CORE_CLK);
		tally_and_finish();
	end
endmodule : host_processor_bus_port_tb_top
